// ### rtl/fe_cfg_pkg.sv
// Package with register map, field layout, reset values and timing for the front-end config bank.
package fe_cfg_pkg;

	// ------------------------------------------------------------
	// Register indices; the bus byte address is four times the index.
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_DRV_NEG   = 8'h0E; // Drive negative select index.
	localparam logic [7:0] IDX_LO_POS_EN = 8'h0F; // Positive lead-off enable index.
	localparam logic [7:0] IDX_LO_NEG_EN = 8'h10; // Negative lead-off enable index.
	localparam logic [7:0] IDX_LO_DIR    = 8'h11; // Current direction index.
	localparam logic [7:0] IDX_LO_POS_ST = 8'h12; // Positive status index.
	localparam logic [7:0] IDX_LO_NEG_ST = 8'h13; // Negative status index.
	localparam logic [7:0] IDX_PINS      = 8'h14; // General pin control index.
	localparam logic [7:0] IDX_PULSE     = 8'h15; // Pulse detect routing index.
	localparam logic [7:0] IDX_BREATH    = 8'h16; // Breathing control index.
	localparam logic [7:0] IDX_CFG4      = 8'h17; // Configuration four index.
	localparam logic [7:0] IDX_RATE      = 8'h20; // Data rate status index.

	// ------------------------------------------------------------
	// Reset values.
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CHAN   = 8'h00; // Per-channel registers clear.
	localparam logic [7:0] RST_PINS   = 8'h0F; // Directions all input; reset breathing mode 01 drives pins two to four.
	localparam logic [7:0] RST_PULSE  = 8'h00; // Channels 2 and 1, buffer off.
	localparam logic [7:0] RST_BREATH = 8'h15; // Phase 101, mode 01.
	localparam logic [7:0] RST_CFG4   = 8'h00; // Continuous, link off, comparators off.

	// ------------------------------------------------------------
	// Field writable masks (reserved bits hold zero).
	// ------------------------------------------------------------
	localparam logic [7:0] MASK_PULSE  = 8'h1F; // Bits 4:0 writable.
	localparam logic [7:0] MASK_BREATH = 8'h1F; // Bits 4:0 writable.
	localparam logic [7:0] MASK_CFG4   = 8'hEE; // Bits 7:5 and 3:1 writable.

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int POS_EVEN  = 3; // Even channel select, two bits.
	localparam int POS_ODD   = 1; // Odd channel select, two bits.
	localparam int POS_PBUF  = 0; // Pulse buffer enable.
	localparam int POS_PHASE = 2; // Breathing phase, three bits.
	localparam int POS_MODE  = 0; // Breathing mode, two bits.
	localparam int POS_FREQ  = 5; // Breathing frequency, three bits.
	localparam int POS_SHOT  = 3; // Single-shot select.
	localparam int POS_LINK  = 2; // Terminal to drive link.
	localparam int POS_COMP  = 1; // Comparator enable.
	localparam logic [2:0] PHASE_180 = 3'h7; // Code for half a period.
	localparam logic [2:0] FREQ_LAST_PROG = 3'h1; // Highest code using programmed phase.

	// ------------------------------------------------------------
	// Timing: 25 MHz system clock.
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000; // System clock rate.
	localparam int NOM_CTRL_HZ = 2_048_000; // Nominal converter clock.
	localparam int BREATH_TOP_HZ = 64_000; // Fastest breathing control rate.
	// Half-period of the fastest breathing clock in system cycles, rounded down.
	localparam int BREATH_HALF_CYC = CLK_HZ / (2 * BREATH_TOP_HZ);

	// AXI4-Lite response codes.
	localparam logic [1:0] BREATHING_CONTROL_OKAY   = 2'h0; // Normal access.
	localparam logic [1:0] BREATHING_CONTROL_SLVERR = 2'h2; // Unmapped address.

	// Grouped analog control outputs.
	typedef struct packed {
		logic [7:0] drive_neg_sel;   // Per-channel drive selection.
		logic [7:0] lo_pos_en;       // Positive lead-off enables.
		logic [7:0] lo_neg_en;       // Negative lead-off enables.
		logic [7:0] lo_dir;          // Current direction bits.
		logic [7:0] even_pulse_onehot; // Channel routed to even output.
		logic [7:0] odd_pulse_onehot;  // Channel routed to odd output.
		logic       pulse_buf_en;    // Pulse buffer power.
		logic       single_shot;     // Single-shot conversion.
		logic       term_link;       // Terminal to drive link.
		logic       comp_en;         // Comparator power.
	} analog_ctrl_type;

endpackage

// ### rtl/fe_cfg_regs.sv
// Configuration and status register bank of the biopotential front-end with AXI4-Lite access.
`timescale 1ns/1ps
module fe_cfg_regs #(
	parameter int NUM_CHANNELS = 8 // Variant channel count: 4, 6 or 8.
) (
	// Clock and reset.
	input  wire logic                        clk_sys,
	input  wire logic                        nrst,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read address and data.
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Analog status from the comparators (asynchronous).
	input  wire logic [7:0]                  leadoff_pos_status_in,
	input  wire logic [7:0]                  leadoff_neg_status_in,
	input  wire logic                        rate_is_32ksps, // Converter at top data rate.
	// General pins as three signals each.
	input  wire logic [3:0]                  pin_in,
	output logic [3:0]                       pin_out,
	output logic [3:0]                       pin_oe,
	// Analog controls.
	output fe_cfg_pkg::analog_ctrl_type      analog_ctrl,
	output logic [1:0]                       breathing_mode,
	output logic [2:0]                       breathing_frequency
);

	// ------------------------------------------------------------
	// Storage.
	// ------------------------------------------------------------
	logic [7:0] drv_neg_ff;    // Drive negative select register.
	logic [7:0] lo_pos_en_ff;  // Positive lead-off enable register.
	logic [7:0] lo_neg_en_ff;  // Negative lead-off enable register.
	logic [7:0] lo_dir_ff;     // Current direction register.
	logic [3:0] pin_data_ff;   // Pin data latch.
	logic [3:0] pin_dir_ff;    // Pin direction, one is input.
	logic [7:0] pulse_ff;      // Pulse routing register.
	logic [7:0] breath_ff;     // Breathing control register.
	logic [7:0] cfg4_ff;       // Configuration four register.
	logic [7:0] pos_st_s1_ff;  // Positive status first stage.
	logic [7:0] pos_st_ff;     // Positive status synchronised.
	logic [7:0] neg_st_s1_ff;  // Negative status first stage.
	logic [7:0] neg_st_ff;     // Negative status synchronised.
	logic [3:0] pin_s1_ff;     // Pin level first stage.
	logic [3:0] pin_ff;        // Pin level synchronised.
	logic       rate_s1_ff;    // Rate flag first stage.
	logic       rate_ff;       // Rate flag synchronised.

	// Mask of implemented channel bits for this variant.
	localparam logic [7:0] CHAN_MASK = (NUM_CHANNELS >= 8) ? 8'hFF :
		(NUM_CHANNELS >= 6) ? 8'h3F : 8'h0F;

	// ------------------------------------------------------------
	// Input synchronisers.
	// ------------------------------------------------------------
	// Two flip-flops on every asynchronous input.
	always_ff @(posedge clk_sys) begin
		pos_st_s1_ff <= leadoff_pos_status_in;
		pos_st_ff    <= pos_st_s1_ff;
		neg_st_s1_ff <= leadoff_neg_status_in;
		neg_st_ff    <= neg_st_s1_ff;
		pin_s1_ff    <= pin_in;
		pin_ff       <= pin_s1_ff;
		rate_s1_ff   <= rate_is_32ksps;
		rate_ff      <= rate_s1_ff;
	end

	// ------------------------------------------------------------
	// AXI4-Lite write path.
	// ------------------------------------------------------------
	logic       aw_held_ff;   // Write address captured.
	logic       w_held_ff;    // Write data captured.
	logic [7:0] aw_addr_ff;   // Captured write address.
	logic [7:0] w_data_ff;    // Captured write data low byte.
	logic       w_strb_ff;    // Captured low byte lane enable.
	logic       do_write;     // Both halves present, commit this cycle.
	logic       wr_hit;       // Write address maps to a register.

	assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

	// Address and data are taken in either order and held until commit.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 8'h00;
			w_strb_ff     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
			end
			if (s_axi_awvalid && !aw_held_ff && !s_axi_awready) begin
				aw_held_ff    <= 1'b1;
				aw_addr_ff    <= s_axi_awaddr;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && !w_held_ff && !s_axi_wready) begin
				w_held_ff    <= 1'b1;
				w_data_ff    <= s_axi_wdata[7:0];
				w_strb_ff    <= s_axi_wstrb[0];
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Register index decode.
	// ------------------------------------------------------------
	// Each register is one aligned word, so its index is the byte address over four.
	logic [7:0] wr_idx;     // Register index of the held write address.
	logic [7:0] rd_idx;     // Register index of the read address.
	logic       wr_aligned; // Held write address falls on a word boundary.
	logic       rd_aligned; // Read address falls on a word boundary.
	assign wr_idx     = {2'b00, aw_addr_ff[7:2]};
	assign rd_idx     = {2'b00, s_axi_araddr[7:2]};
	assign wr_aligned = (aw_addr_ff[1:0] == 2'b00);
	assign rd_aligned = (s_axi_araddr[1:0] == 2'b00);

	// Decode of mapped addresses, read-only status and rate included; a misaligned address maps to nothing.
	always_comb begin
		case (wr_idx)
			fe_cfg_pkg::IDX_DRV_NEG, fe_cfg_pkg::IDX_LO_POS_EN, fe_cfg_pkg::IDX_LO_NEG_EN,
			fe_cfg_pkg::IDX_LO_DIR, fe_cfg_pkg::IDX_LO_POS_ST, fe_cfg_pkg::IDX_LO_NEG_ST,
			fe_cfg_pkg::IDX_PINS, fe_cfg_pkg::IDX_PULSE, fe_cfg_pkg::IDX_BREATH,
			fe_cfg_pkg::IDX_CFG4, fe_cfg_pkg::IDX_RATE: wr_hit = wr_aligned;
			default: wr_hit = 1'b0;
		endcase
	end

	// Write response one cycle after commit; unmapped gives slave error.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= fe_cfg_pkg::BREATHING_CONTROL_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? fe_cfg_pkg::BREATHING_CONTROL_OKAY : fe_cfg_pkg::BREATHING_CONTROL_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	logic wr_en; // Commit with the low byte lane enabled.
	assign wr_en = do_write && w_strb_ff && wr_aligned;

	// ------------------------------------------------------------
	// Per-channel registers.
	// ------------------------------------------------------------
	// Unimplemented channel bits never store a one.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			drv_neg_ff   <= fe_cfg_pkg::RST_CHAN;
			lo_pos_en_ff <= fe_cfg_pkg::RST_CHAN;
			lo_neg_en_ff <= fe_cfg_pkg::RST_CHAN;
			lo_dir_ff    <= fe_cfg_pkg::RST_CHAN;
		end else if (wr_en) begin
			case (wr_idx)
				fe_cfg_pkg::IDX_DRV_NEG:   drv_neg_ff   <= w_data_ff & CHAN_MASK;
				fe_cfg_pkg::IDX_LO_POS_EN: lo_pos_en_ff <= w_data_ff & CHAN_MASK;
				fe_cfg_pkg::IDX_LO_NEG_EN: lo_neg_en_ff <= w_data_ff & CHAN_MASK;
				fe_cfg_pkg::IDX_LO_DIR:    lo_dir_ff    <= w_data_ff & CHAN_MASK;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// General pin register.
	// ------------------------------------------------------------
	logic [3:0] pin_taken; // Pins owned by the breathing function.
	assign pin_taken = (breath_ff[fe_cfg_pkg::POS_MODE]) ? 4'hE : 4'h0;

	// Data bits only land on pins that were outputs before this write.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pin_dir_ff  <= fe_cfg_pkg::RST_PINS[3:0];
			pin_data_ff <= 4'h0;
		end else if (wr_en && wr_idx == fe_cfg_pkg::IDX_PINS) begin
			pin_dir_ff  <= w_data_ff[3:0];
			for (int i = 0; i < 4; i++) begin
				if (!pin_dir_ff[i]) begin
					pin_data_ff[i] <= w_data_ff[4 + i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pulse, breathing and configuration four registers.
	// ------------------------------------------------------------
	// Reserved bits are masked so they always hold zero.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pulse_ff  <= fe_cfg_pkg::RST_PULSE;
			breath_ff <= fe_cfg_pkg::RST_BREATH;
			cfg4_ff   <= fe_cfg_pkg::RST_CFG4;
		end else if (wr_en) begin
			case (wr_idx)
				fe_cfg_pkg::IDX_PULSE:  pulse_ff  <= w_data_ff & fe_cfg_pkg::MASK_PULSE;
				fe_cfg_pkg::IDX_BREATH: breath_ff <= w_data_ff & fe_cfg_pkg::MASK_BREATH;
				fe_cfg_pkg::IDX_CFG4:   cfg4_ff   <= w_data_ff & fe_cfg_pkg::MASK_CFG4;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Breathing demodulation clocks on pins three and four.
	// ------------------------------------------------------------
	logic [15:0] half_cyc;     // Half period for the selected frequency.
	logic [15:0] base_cnt_ff;  // Period counter of the reference pin.
	logic        ref_ff;       // Reference demodulation clock.
	logic [15:0] delay_cyc;    // Delay of the shifted clock in cycles.
	logic [2:0]  eff_phase;    // Phase code actually used.
	logic [2:0]  freq;         // Frequency code.

	assign freq = cfg4_ff[fe_cfg_pkg::POS_FREQ +: 3];
	assign half_cyc = 16'(fe_cfg_pkg::BREATH_HALF_CYC) << freq;

	// Programmed phase only at the top data rate and two fastest codes.
	always_comb begin
		if (rate_ff && freq <= fe_cfg_pkg::FREQ_LAST_PROG) begin
			eff_phase = breath_ff[fe_cfg_pkg::POS_PHASE +: 3];
		end else begin
			eff_phase = fe_cfg_pkg::PHASE_180;
		end
	end
	// Phase step is one eighth of a half period per code plus one.
	assign delay_cyc = 16'((32'(half_cyc) * (32'(eff_phase) + 32'd1)) >> 3);

	// Reference clock toggles every half period.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			base_cnt_ff <= 16'h0000;
			ref_ff      <= 1'b0;
		end else if (base_cnt_ff + 16'h0001 >= (half_cyc << 1)) begin
			base_cnt_ff <= 16'h0000;
			ref_ff      <= 1'b0;
		end else begin
			base_cnt_ff <= base_cnt_ff + 16'h0001;
			if (base_cnt_ff + 16'h0001 == half_cyc) begin
				ref_ff <= 1'b1;
			end
		end
	end

	logic [16:0] shifted_pos; // Counter position of the delayed clock.
	logic        shift_clk;   // Delayed demodulation clock.
	always_comb begin
		shifted_pos = 17'(base_cnt_ff) + 17'(half_cyc << 1) - 17'(delay_cyc);
		if (shifted_pos >= 17'(half_cyc << 1)) begin
			shifted_pos = shifted_pos - 17'(half_cyc << 1);
		end
		shift_clk = (shifted_pos >= 17'(half_cyc));
	end

	// ------------------------------------------------------------
	// Pin drivers.
	// ------------------------------------------------------------
	// Breathing modes with mode bit zero set (01 and 11) override pins two to four.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pin_out <= 4'h0;
			pin_oe  <= 4'h0;
		end else begin
			pin_oe  <= ~pin_dir_ff | pin_taken;
			pin_out <= pin_taken[3] ? {shift_clk, ref_ff, 1'b0, pin_data_ff[0]} : pin_data_ff;
		end
	end

	// ------------------------------------------------------------
	// Analog control outputs.
	// ------------------------------------------------------------
	logic [1:0] even_sel; // Even channel code.
	logic [1:0] odd_sel;  // Odd channel code.
	assign even_sel = pulse_ff[fe_cfg_pkg::POS_EVEN +: 2];
	assign odd_sel  = pulse_ff[fe_cfg_pkg::POS_ODD +: 2];

	// Decode routes exactly one channel to each pulse output.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			analog_ctrl         <= '0;
			breathing_mode      <= fe_cfg_pkg::RST_BREATH[1:0];
			breathing_frequency <= 3'h0;
		end else begin
			analog_ctrl.drive_neg_sel     <= drv_neg_ff;
			analog_ctrl.lo_pos_en         <= lo_pos_en_ff;
			analog_ctrl.lo_neg_en         <= lo_neg_en_ff;
			analog_ctrl.lo_dir            <= lo_dir_ff;
			analog_ctrl.even_pulse_onehot <= 8'h02 << {even_sel, 1'b0};
			analog_ctrl.odd_pulse_onehot  <= 8'h01 << {odd_sel, 1'b0};
			analog_ctrl.pulse_buf_en      <= pulse_ff[fe_cfg_pkg::POS_PBUF];
			analog_ctrl.single_shot       <= cfg4_ff[fe_cfg_pkg::POS_SHOT];
			analog_ctrl.term_link         <= cfg4_ff[fe_cfg_pkg::POS_LINK];
			analog_ctrl.comp_en           <= cfg4_ff[fe_cfg_pkg::POS_COMP];
			breathing_mode                <= breath_ff[fe_cfg_pkg::POS_MODE +: 2];
			breathing_frequency           <= cfg4_ff[fe_cfg_pkg::POS_FREQ +: 3];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read path.
	// ------------------------------------------------------------
	logic [7:0] rd_byte; // Selected read value.
	logic       rd_hit;  // Read address maps to a register.

	// Read multiplexer; status is masked to the implemented channel bits.
	always_comb begin
		rd_hit = 1'b1;
		case (rd_idx)
			fe_cfg_pkg::IDX_DRV_NEG:   rd_byte = drv_neg_ff;
			fe_cfg_pkg::IDX_LO_POS_EN: rd_byte = lo_pos_en_ff;
			fe_cfg_pkg::IDX_LO_NEG_EN: rd_byte = lo_neg_en_ff;
			fe_cfg_pkg::IDX_LO_DIR:    rd_byte = lo_dir_ff;
			fe_cfg_pkg::IDX_LO_POS_ST: rd_byte = pos_st_ff & CHAN_MASK;
			fe_cfg_pkg::IDX_LO_NEG_ST: rd_byte = neg_st_ff & CHAN_MASK;
			fe_cfg_pkg::IDX_PINS:      rd_byte = {pin_ff, pin_dir_ff};
			fe_cfg_pkg::IDX_PULSE:     rd_byte = pulse_ff;
			fe_cfg_pkg::IDX_BREATH:    rd_byte = breath_ff;
			fe_cfg_pkg::IDX_CFG4:      rd_byte = cfg4_ff;
			fe_cfg_pkg::IDX_RATE:      rd_byte = {7'h00, rate_ff};
			default: begin
				rd_byte = 8'h00;
				rd_hit  = 1'b0;
			end
		endcase
		// A misaligned read hits no register and returns zero.
		if (!rd_aligned) begin
			rd_byte = 8'h00;
			rd_hit  = 1'b0;
		end
	end

	// Read data is valid in the same cycle as the address is taken.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= fe_cfg_pkg::BREATHING_CONTROL_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h00_0000, rd_byte};
				s_axi_rresp   <= rd_hit ? fe_cfg_pkg::BREATHING_CONTROL_OKAY : fe_cfg_pkg::BREATHING_CONTROL_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // fe_cfg_regs

// ### tb/fe_cfg_regs_props.sv
// Checker of bus handshakes and control outputs of the config bank.
`timescale 1ns/1ps
module fe_cfg_regs_props #(
	parameter int NUM_CHANNELS = 8 // Channels present in the variant.
) (
	// Clock and reset.
	input wire logic                   clk_sys,
	input wire logic                   nrst,
	// Register bus.
	input wire logic                   s_axi_awready,
	input wire logic [1:0]             s_axi_bresp,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	// Pins and controls.
	input wire logic [3:0]             pin_oe,
	input wire fe_cfg_pkg::analog_ctrl_type analog_ctrl,
	input wire logic [1:0]             breathing_mode
);
	// Channel bits that exist in this variant.
	localparam logic [7:0] CH_MASK = 8'hFF >> (8 - NUM_CHANNELS);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data above byte");
	a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write answer missing");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready too long");
	a_mode_pins: assert property (breathing_mode[0] [*3] |-> pin_oe[3:1] == 3'b111)
		else $error("breathing pins not taken");
	a_pulse_onehot: assert property ($past(nrst) |-> $onehot(analog_ctrl.even_pulse_onehot)
		&& $onehot(analog_ctrl.odd_pulse_onehot))
		else $error("pulse routing not one channel");
	a_chan_mask: assert property ((analog_ctrl.drive_neg_sel & ~CH_MASK) == 8'h00)
		else $error("missing channel bit set");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // fe_cfg_regs_props

bind fe_cfg_regs fe_cfg_regs_props #(.NUM_CHANNELS(NUM_CHANNELS)) props_inst (.clk_sys(clk_sys),
	.nrst(nrst), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pin_oe(pin_oe), .analog_ctrl(analog_ctrl), .breathing_mode(breathing_mode));

// ### tb/pin_world.sv
// Model of the outside world on the general pins of the config bank.
`timescale 1ns/1ps
module pin_world (
	// Pins from the bank.
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	// Level applied where the bank does not drive.
	input wire logic [3:0] ext_level,
	// Resolved pin levels.
	output logic [3:0]     pin_in
);
	// A pin follows the bank where it drives and the outside level elsewhere.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_world

// ### tb/testbench.sv
// Self-checking bench of the config bank over its register bus.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	logic clk_sys, nrst, awv, wv, bv, brd, arv, rv, rrd, awr, wrdy, arr, rate;
	logic [7:0] awa, ara, lop, lon;
	logic [31:0] wd, rdat;
	logic [3:0] ws, pin_in, pin_out, pin_oe, ext;
	logic [1:0] br, rr, mode;
	logic [2:0] freq;
	fe_cfg_pkg::analog_ctrl_type actl;
	int fails, cmp_count;
	fe_cfg_regs #(.NUM_CHANNELS(6)) fe_cfg_regs_inst (.clk_sys(clk_sys), .nrst(nrst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrd), .leadoff_pos_status_in(lop), .leadoff_neg_status_in(lon),
		.rate_is_32ksps(rate), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.analog_ctrl(actl), .breathing_mode(mode), .breathing_frequency(freq));
	pin_world pin_world_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
		.pin_in(pin_in));
	// Free-running 25 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// One bus write: address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk_sys);
		awa <= {a[5:0], 2'b00}; // Word address of register index a.
		awv <= 1'b1;
		wd <= {24'h00_0000, d};
		ws <= 4'hF;
		wv <= 1'b1;
		brd <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge clk_sys);
			if (awr) begin ad = 1'b1; awv <= 1'b0; end
			if (wrdy) begin dd = 1'b1; wv <= 1'b0; end
		end
		while (!bv) @(posedge clk_sys);
		r = br;
		brd <= 1'b0;
	endtask
	// One bus read.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		ara <= {a[5:0], 2'b00}; // Word address of register index a.
		arv <= 1'b1;
		rrd <= 1'b1;
		do @(posedge clk_sys); while (!arr);
		arv <= 1'b0;
		while (!rv) @(posedge clk_sys);
		d = rdat[7:0];
		r = rr;
		rrd <= 1'b0;
	endtask
	task automatic ck_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK({d, r}, {e, 2'h0})
	endtask
	// Write expecting success, then let registered outputs and synchronisers settle.
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK(r, 2'h0)
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic t_reset;
		for (logic [7:0] a = 8'h0E; a < 8'h12; a++) ck_rd(a, 8'h00);
		ck_rd(8'h15, 8'h00);
		ck_rd(8'h16, 8'h15);
		ck_rd(8'h17, 8'h00);
		`CHK(pin_oe[0], 1'b0)
	endtask
	task automatic t_chan;
		for (logic [7:0] a = 8'h0E; a < 8'h12; a++) begin
			put(a, 8'hFF);
			ck_rd(a, 8'h3F);
		end
		`CHK({actl.drive_neg_sel, actl.lo_pos_en}, 16'h3F3F)
		`CHK({actl.lo_neg_en, actl.lo_dir}, 16'h3F3F)
	endtask
	task automatic t_status;
		lop <= 8'h25;
		lon <= 8'h1A;
		rate <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ck_rd(8'h12, 8'h25);
		ck_rd(8'h13, 8'h1A);
		put(8'h12, 8'hFF);
		ck_rd(8'h12, 8'h25);
		ck_rd(8'h20, 8'h01);
	endtask
	task automatic t_cfg4;
		put(8'h17, 8'hEE);
		ck_rd(8'h17, 8'hEE);
		`CHK({freq, actl.single_shot, actl.term_link, actl.comp_en}, 6'h3F)
		put(8'h17, 8'h48);
		`CHK({freq, actl.single_shot, actl.term_link, actl.comp_en}, 6'h14)
	endtask
	task automatic t_pulse;
		for (int e = 0; e < 3; e++) begin
			put(8'h15, 8'((e << 3) | ((2 - e) << 1) | (e & 1)));
			`CHK(actl.even_pulse_onehot, 8'h02 << (2 * e))
			`CHK(actl.odd_pulse_onehot, 8'h01 << (2 * (2 - e)))
			`CHK(actl.pulse_buf_en, e[0])
		end
	endtask
	task automatic t_pins;
		ext <= 4'h4;
		put(8'h16, 8'h00);
		put(8'h14, 8'h50);
		`CHK({pin_oe, pin_out}, 8'hF0)
		ck_rd(8'h14, 8'h00);
		put(8'h14, 8'hAC);
		`CHK({pin_oe, pin_out}, 8'h3A)
		ck_rd(8'h14, 8'h6C);
	endtask
	task automatic t_breath;
		for (int m = 0; m < 4; m++) begin
			put(8'h16, 8'(8'h1C | m));
			ck_rd(8'h16, 8'(8'h1C | m));
			`CHK(mode, 2'(m))
			`CHK(pin_oe[3:1], m[0] ? 3'b111 : 3'b001)
		end
	endtask
	// Breathing clocks at frequency code 1: pin four trails pin three by the phase.
	task automatic t_clock(input logic r, input int e);
		int n;
		n = 0;
		rate <= r;
		put(8'h17, 8'h20);
		put(8'h16, 8'h0D);
		while (pin_out[2]) @(posedge clk_sys);
		while (!pin_out[2]) @(posedge clk_sys);
		while (!pin_out[3]) begin n++; @(posedge clk_sys); end
		`CHK(n, e)
		while (pin_out[2]) begin n++; @(posedge clk_sys); end
		`CHK(n, 2 * fe_cfg_pkg::BREATH_HALF_CYC)
		`CHK(pin_out[1], 1'b0)
	endtask
	task automatic t_bad;
		logic [7:0] d;
		logic [1:0] r;
		wr(8'h30, 8'h5A, r);
		`CHK(r, 2'h2)
		rd(8'h30, d, r);
		`CHK({d, r}, 10'h002)
	endtask
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Watchdog well beyond the few thousand cycles the tests need.
	initial begin
		#(40 * 20000);
		fails++;
		finish_test;
	end
	// Main sequence.
	initial begin
		{nrst, awv, wv, brd, arv, rrd, rate, awa, ara, wd, ws} = '0;
		{lop, lon, ext} = '0;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset;
		t_chan;
		t_status;
		t_cfg4;
		t_pulse;
		t_pins;
		t_breath;
		// Quarter period at 90 degrees, half period once the rate drops.
		t_clock(1'b1, fe_cfg_pkg::BREATH_HALF_CYC);
		t_clock(1'b0, 2 * fe_cfg_pkg::BREATH_HALF_CYC);
		t_bad;
		finish_test;
	end
endmodule // testbench
